/* File: core/rcs_pkg.sv */
// Constants, types and register map of the reset and clock sequencer.
package rcs_pkg;
  // Clock period in ns of the internal oscillator clock.
  localparam int CLK_NS = 50;
  // Long stabilisation count, stop and reset phase lengths in clock cycles.
  localparam int LONG_CYC = 4096;
  localparam int SHORT_STOP_CYC = 32;
  localparam int DRIVE_CYC = 32;
  localparam int TAIL_CYC = 32;
  localparam int SYNC_CYC = 3;
  localparam int BUS_DIV = 4;
  // Least low time of the reset pin before its flag is set.
  localparam int PIN_MIN_NS = 200;
  localparam int PIN_MIN_CYC = (PIN_MIN_NS + CLK_NS - 1) / CLK_NS;
  // Stabilisation counter: bits 12 down to 1, service clears 12 down to 5.
  localparam int CNT_HI = 12;
  localparam int CNT_LO = 1;
  localparam int SVC_LO = 5;
  localparam logic [11:0] CNT_MAX = 12'hfff;
  localparam int OVF_BOUND = 8176;
  // Watchdog counter width.
  localparam int WDOG_W = 6;
  // Reset vectors and the watchdog service address.
  localparam logic [15:0] VEC_USER = 16'hfffe;
  localparam logic [15:0] VEC_MON = 16'hfefe;
  localparam logic [15:0] SVC_ADDR = 16'hffff;
  // Reset cause register bit positions.
  localparam int F_POR = 7;
  localparam int F_PIN = 6;
  localparam int F_WDOG = 5;
  localparam int F_BADOP = 4;
  localparam int F_BADADR = 3;
  localparam int F_MON = 2;
  localparam int F_UV = 1;
  localparam logic [7:0] FLAGS_POR = 8'h80;
  // Register offsets of the plain register port.
  localparam logic [1:0] REG_CAUSE = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_STAT = 2'h2;
  // Sequencer states.
  typedef enum logic [3:0] {
    S_RUN, S_WAIT, S_STOP, S_RECOV, S_PIN, S_LONG, S_DRIVE, S_TAIL, S_SYNC
  } rcs_state_t;
endpackage

/* File: core/rcs_cnt_if.sv */
// Interface between the sequencer and its stabilisation counter.
`timescale 1ns/100ps
interface rcs_cnt_if;
  logic        clear_all;  // Clears the whole counter.
  logic        clear_hi;   // Clears the upper bits on watchdog service.
  logic [12:1] value;      // Present count.
  logic        ovf;        // One-cycle overflow pulse.
  modport ctl (output clear_all, output clear_hi, input value, input ovf);
  modport cnt (input clear_all, input clear_hi, output value, output ovf);
endinterface

/* File: core/rcs_stab_counter.sv */
// Free-running 12-bit stabilisation counter with its overflow pulse.
`timescale 1ns/100ps
module rcs_stab_counter
  import rcs_pkg::*;
(
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESETN,
  // Counter controls and outputs.
  rcs_cnt_if.cnt   cif
);
  // Whole state of the counter.
  typedef struct packed {
    logic [12:1] v;
    logic        ovf;
  } rcs_cnt_t;

  rcs_cnt_t q;  // Registered state.
  rcs_cnt_t d;  // Next state.

  // Counts every cycle; a clear wins over counting.
  always_comb begin
    d = q;
    {d.ovf, d.v} = {1'b0, q.v} + 13'h1;
    if (cif.clear_all) begin
      d.v = '0;
      d.ovf = 1'b0;
    end
    if (cif.clear_hi) begin
      d.v[CNT_HI:SVC_LO] = '0;
    end
  end

  // Registers the state.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cif.value = q.v;
  assign cif.ovf = q.ovf;

  // Cycles since the last overflow or whole clear, for checking only.
  // A whole clear restarts the count; a service clear does not, so the bound also covers stretches with a service.
  logic [13:0] since_q;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      since_q <= '0;
    end else begin
      since_q <= (q.ovf || cif.clear_all) ? 14'h0 : since_q + 14'h1;
    end
  end

  a_ovf_period : assert property (@(posedge REF_CLK) disable iff (!RESETN)
    since_q <= 14'(OVF_BOUND)) else $error("overflow came too late");
  a_free_count : assert property (@(posedge REF_CLK) disable iff (!RESETN)
    !cif.clear_all && !cif.clear_hi |=> q.v == $past(q.v) + 12'h1)
    else $error("counter did not advance");
  a_svc_hi_clear : assert property (@(posedge REF_CLK) disable iff (!RESETN)
    cif.clear_hi |=> q.v[CNT_HI:SVC_LO] == '0) else $error("service left high bits");
endmodule

/* File: core/rcs_sequencer.sv */
// Reset and clock start-up sequencer with cause flags and watchdog.
// Contract
// - Bus tick is selected source divided by four.
// - Power-up holds clocks off, pin low.
// - Stop wake waits selectable delay, clocks off.
// - Wait mode stops CPU clock only.
// - Any reset asserts internal reset, picks vector.
// - Internal reset clears counter; pin reset not.
// - Pin low halts; flag after minimum time.
// - Recovery lasts 4163 or 67 cycles.
// - Internal reset: pin 32, then 32 more.
// - Power-up/undervoltage pin low 4096 plus 32.
// - Power-up sets its flag, clears others.
// - Thirty-two more cycles before CPU release; the code holds 35, adding 3 sync cycles after the 32.
// - Watchdog overflow resets and sets flag.
// - Write to FFFF services watchdog and counter.
// - Counter overflow at least every bound.
// - Watchdog disabled only by test voltage.
// - Illegal opcode or disabled stop resets.
// - Unmapped fetch resets; data access does not.
// - Undervoltage sets flag, long hold sequence.
// - Monitor entry reset drives pin, resets.
// - Stop clears counter; wake delay by option.
// - Twelve-bit counter runs freely after reset.
`timescale 1ns/100ps
module rcs_sequencer
  import rcs_pkg::*;
(
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        RESETN,
  // Clock source ticks and bus clock output.
  input  wire logic        OSC_SELECT_CLOCK_TICK,
  input  wire logic        PLL_DIV_CLOCK_TICK,
  output logic             BUS_TICK,
  output logic             CPU_CLK_EN,
  output logic             PERIPH_CLK_EN,
  // Reset sources.
  input  wire logic        POWER_UP_PULSE,
  input  wire logic        UNDERVOLTAGE_RESET,
  input  wire logic        MONITOR_ENTRY_RESET,
  input  wire logic        ILLEGAL_OPCODE,
  input  wire logic        OPCODE_FETCH,
  input  wire logic        UNMAPPED_ADDR,
  // CPU mode requests and options.
  input  wire logic        STOP_OPCODE,
  input  wire logic        WAIT_REQ,
  input  wire logic        WAKE_EVENT,
  input  wire logic        STOP_ENABLE_OPTION,
  input  wire logic        SHORT_STOP_RECOVERY_OPTION,
  input  wire logic        MONITOR_MODE,
  input  wire logic        BREAK_STATE,
  // Test voltage detectors.
  input  wire logic        TEST_HIGH_VOLTAGE_RST,
  input  wire logic        TEST_HIGH_VOLTAGE_EXT_INTERRUPT_ONE_PIN,
  // CPU write port for the watchdog service.
  input  wire logic        CPU_WRITE,
  input  wire logic [15:0] CPU_ADDR,
  // Open-drain reset pin.
  input  wire logic        RST_PIN_IN,
  output logic             RST_PIN_OUT,
  output logic             RST_PIN_OE,
  // Reset results.
  output logic             INTERNAL_RESET_LINE,
  output logic [15:0]      RESET_VECTOR,
  output logic             WATCHDOG_DISABLED,
  // Register port.
  input  wire logic [1:0]  REG_ADDR,
  input  wire logic [7:0]  REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic [7:0]       REG_RDATA
);
  // Whole state of the sequencer.
  typedef struct packed {
    rcs_state_t        st;        // Sequencer state.
    logic [5:0]        phase;     // Cycle count within a short phase.
    logic [2:0]        pin_cnt;   // Cycles the pin was seen low.
    logic [7:0]        flags;     // Reset cause register.
    logic [WDOG_W-1:0] wdog;      // Watchdog counter.
    logic [1:0]        div;       // Bus divider count.
    logic              bus_tick;  // Bus tick pulse.
    logic              pll_sel;   // Source select, 1 picks the PLL clock.
    logic              long_seq;  // Present sequence is the long one.
    logic [15:0]       vec;       // Reset vector.
    logic [7:0]        rdata;     // Register read data.
  } rcs_seq_t;

  rcs_seq_t q;  // Registered state.
  rcs_seq_t d;  // Next state.
  rcs_cnt_if cif ();  // Link to the stabilisation counter.

  // The counter that times stabilisation and clocks the watchdog.
  rcs_stab_counter u_cnt (
    .REF_CLK (REF_CLK),
    .RESETN  (RESETN),
    .cif     (cif)
  );

  logic long_src;   // Power-up or undervoltage.
  logic bad_op;     // Illegal opcode or disabled stop.
  logic bad_fetch;  // Opcode fetch from an unmapped address.
  logic wdog_off;   // Watchdog disabled by test voltage.
  logic wdog_fire;  // Watchdog overflow.
  logic int_src;    // Any internal reset source.
  logic in_reset;   // Any reset state.
  logic svc;        // Watchdog service write.
  logic sel_tick;   // Tick of the selected clock source.

  // Decodes the reset sources from the CPU and the modules.
  always_comb begin
    long_src = POWER_UP_PULSE | UNDERVOLTAGE_RESET;
    bad_op = ILLEGAL_OPCODE | (STOP_OPCODE & ~STOP_ENABLE_OPTION);
    bad_fetch = OPCODE_FETCH & UNMAPPED_ADDR;
    wdog_off = (MONITOR_MODE & (TEST_HIGH_VOLTAGE_RST | TEST_HIGH_VOLTAGE_EXT_INTERRUPT_ONE_PIN))
             | (BREAK_STATE & TEST_HIGH_VOLTAGE_RST);
    wdog_fire = (&q.wdog) & cif.ovf & ~wdog_off;
    int_src = long_src | bad_op | bad_fetch | wdog_fire | MONITOR_ENTRY_RESET;
    in_reset = q.st inside {S_PIN, S_LONG, S_DRIVE, S_TAIL, S_SYNC};
    svc = CPU_WRITE & (CPU_ADDR == SVC_ADDR) & (q.st == S_RUN);
    sel_tick = q.pll_sel ? PLL_DIV_CLOCK_TICK : OSC_SELECT_CLOCK_TICK;
  end

  // Next state of the sequencer, flags, watchdog and registers.
  always_comb begin
    d = q;
    d.bus_tick = 1'b0;
    d.rdata = '0;
    d.vec = MONITOR_MODE ? VEC_MON : VEC_USER;
    cif.clear_all = 1'b0;
    cif.clear_hi = svc;
    // Bus clock is the selected source divided by four.
    if (sel_tick) begin
      d.div = q.div + 2'h1;
      if (q.div == 2'(BUS_DIV - 1)) begin
        d.div = '0;
        d.bus_tick = 1'b1;
      end
    end
    // Watchdog counts counter overflows while the CPU may run.
    if (!(q.st inside {S_RUN, S_WAIT}) || svc) begin
      d.wdog = '0;
    end else if (cif.ovf) begin
      d.wdog = q.wdog + 1'b1;
    end
    // Cause flags; hardware only sets them, power-up clears the rest.
    if (POWER_UP_PULSE) begin
      d.flags = FLAGS_POR;
    end else begin
      d.flags[F_UV] = q.flags[F_UV] | UNDERVOLTAGE_RESET;
      d.flags[F_WDOG] = q.flags[F_WDOG] | wdog_fire;
      d.flags[F_BADOP] = q.flags[F_BADOP] | bad_op;
      d.flags[F_BADADR] = q.flags[F_BADADR] | bad_fetch;
      d.flags[F_MON] = q.flags[F_MON] | MONITOR_ENTRY_RESET;
    end
    // Sources in priority order, then the state sequence.
    if (long_src) begin
      d.st = S_LONG;
      d.long_seq = 1'b1;
      cif.clear_all = 1'b1;
    end else if (int_src) begin
      d.st = S_DRIVE;
      d.phase = '0;
      d.long_seq = 1'b0;
      cif.clear_all = 1'b1;
    end else if (!RST_PIN_IN && !RST_PIN_OE && q.st != S_PIN) begin
      d.st = S_PIN;
      d.pin_cnt = '0;
    end else begin
      unique case (q.st)
        S_RUN: begin
          if (STOP_OPCODE) begin
            d.st = S_STOP;
            cif.clear_all = 1'b1;
          end else if (WAIT_REQ) begin
            d.st = S_WAIT;
          end
        end
        S_WAIT: begin
          if (WAKE_EVENT) begin
            d.st = S_RUN;
          end
        end
        S_STOP: begin
          // The oscillator is taken as idle; the counter stays cleared.
          cif.clear_all = 1'b1;
          if (WAKE_EVENT) begin
            d.st = S_RECOV;
          end
        end
        S_RECOV: begin
          // Counter counts oscillator cycles until the chosen delay.
          if (cif.value == (SHORT_STOP_RECOVERY_OPTION ? 12'(SHORT_STOP_CYC - 1)
                                                       : CNT_MAX)) begin
            d.st = S_RUN;
          end
        end
        S_PIN: begin
          // Pin reset halts processing and leaves the counter alone.
          if (q.pin_cnt != 3'(PIN_MIN_CYC)) begin
            d.pin_cnt = q.pin_cnt + 3'h1;
          end
          if (RST_PIN_IN) begin
            d.flags[F_PIN] = q.flags[F_PIN] | (q.pin_cnt == 3'(PIN_MIN_CYC));
            d.st = S_DRIVE;
            d.phase = '0;
            d.long_seq = 1'b0;
          end
        end
        S_LONG: begin
          if (cif.value == CNT_MAX) begin
            d.st = S_DRIVE;
            d.phase = '0;
          end
        end
        S_DRIVE: begin
          d.phase = q.phase + 6'h1;
          if (q.phase == 6'(DRIVE_CYC - 1)) begin
            d.st = S_TAIL;
            d.phase = '0;
          end
        end
        S_TAIL: begin
          d.phase = q.phase + 6'h1;
          if (q.phase == 6'(TAIL_CYC - 1)) begin
            d.st = S_SYNC;
            d.phase = '0;
          end
        end
        S_SYNC: begin
          d.phase = q.phase + 6'h1;
          if (q.phase == 6'(SYNC_CYC - 1)) begin
            d.st = S_RUN;
            d.phase = '0;
          end
        end
        default: begin
          // An unused state code restarts the short reset sequence.
          d.st = S_DRIVE;
          d.phase = '0;
        end
      endcase
    end
    // The control register returns to its default while any reset stands.
    if (in_reset) begin
      d.pll_sel = 1'b0;
    end else if (REG_WR && REG_ADDR == REG_CTRL) begin
      d.pll_sel = REG_WDATA[0];
    end
    // Read data for the cycle after the strobe; unmapped reads zero.
    if (REG_RD) begin
      unique case (REG_ADDR)
        REG_CAUSE: d.rdata = q.flags;
        REG_CTRL:  d.rdata = {7'h0, q.pll_sel};
        REG_STAT:  d.rdata = {CPU_CLK_EN, PERIPH_CLK_EN, wdog_off, RST_PIN_OE, q.st};
        default:   d.rdata = '0;
      endcase
    end
  end

  // Registers the state; reset starts the long power-up sequence.
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      q <= '0;
      q.st <= S_LONG;
      q.long_seq <= 1'b1;
      q.flags <= FLAGS_POR;
      q.vec <= VEC_USER;
    end else begin
      q <= d;
    end
  end

  // Outputs other than WATCHDOG_DISABLED follow the state registers.
  always_comb begin
    BUS_TICK = q.bus_tick;
    CPU_CLK_EN = (q.st == S_RUN);
    PERIPH_CLK_EN = q.st inside {S_RUN, S_WAIT};
    RST_PIN_OUT = 1'b0;
    RST_PIN_OE = q.st inside {S_LONG, S_DRIVE};
    INTERNAL_RESET_LINE = in_reset;
    RESET_VECTOR = q.vec;
    WATCHDOG_DISABLED = wdog_off;
    REG_RDATA = q.rdata;
  end

  // Cycles since the present reset sequence began, for checking only.
  logic [12:0] rec_q;
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      rec_q <= 13'h1;  // The cycles in reset are the first of the long sequence.
    end else if (int_src || (d.st == S_DRIVE && q.st == S_PIN)) begin
      // Every source restarts the count, just as it restarts the sequence.
      rec_q <= 13'h1;
    end else begin
      rec_q <= rec_q + 13'h1;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);

  a_bus_divide : assert property (BUS_TICK |-> $past(sel_tick))
    else $error("bus tick without source tick");
  a_power_hold : assert property (POWER_UP_PULSE |=> RST_PIN_OE && !CPU_CLK_EN)
    else $error("power-up did not hold pin and clocks");
  a_stop_clocks : assert property (q.st == S_RECOV |-> !CPU_CLK_EN && !PERIPH_CLK_EN)
    else $error("clocks ran in stop recovery");
  a_wait_clocks : assert property (q.st == S_WAIT |-> !CPU_CLK_EN && PERIPH_CLK_EN)
    else $error("wait mode clock gating wrong");
  a_reset_vector : assert property (int_src |=> INTERNAL_RESET_LINE ##0
    RESET_VECTOR == ($past(MONITOR_MODE) ? VEC_MON : VEC_USER)) else $error("bad vector");
  a_pin_keeps_cnt : assert property (q.st == S_PIN && !int_src |-> !cif.clear_all)
    else $error("pin reset cleared counter");
  a_pin_flag : assert property ($rose(q.flags[F_PIN]) |-> $past(q.st == S_PIN))
    else $error("pin flag set outside pin reset");
  a_recovery_len : assert property (q.st == S_SYNC && q.phase == 6'(SYNC_CYC - 1)
    && !int_src && RST_PIN_IN |-> rec_q == (q.long_seq
    ? 13'(LONG_CYC + DRIVE_CYC + TAIL_CYC + SYNC_CYC)
    : 13'(DRIVE_CYC + TAIL_CYC + SYNC_CYC))) else $error("recovery length wrong");
  a_drive_then_tail : assert property ($rose(q.st == S_TAIL)
    |-> $past(q.st == S_DRIVE && q.phase == 6'(DRIVE_CYC - 1))) else $error("short drive");
  a_long_pin_low : assert property (q.st == S_LONG |-> RST_PIN_OE && INTERNAL_RESET_LINE)
    else $error("pin released in long hold");
  a_por_flags : assert property (POWER_UP_PULSE |=> q.flags == FLAGS_POR)
    else $error("power-up flags wrong");
  a_wdog_reset : assert property (wdog_fire |=> q.flags[F_WDOG] && RST_PIN_OE)
    else $error("watchdog overflow did not reset");
  a_wdog_service : assert property (svc && !int_src |=> q.wdog == '0)
    else $error("service left watchdog count");
  a_wdog_blocked : assert property (wdog_off |=> !q.flags[F_WDOG] || $past(q.flags[F_WDOG])
    || $past(POWER_UP_PULSE)) else $error("disabled watchdog fired");
  a_bad_opcode : assert property (bad_op && !POWER_UP_PULSE |=> q.flags[F_BADOP])
    else $error("bad opcode not flagged");
  a_data_unmapped : assert property (q.st == S_RUN && UNMAPPED_ADDR && !int_src
    && RST_PIN_IN |=> !INTERNAL_RESET_LINE) else $error("data access reset");
  a_undervoltage : assert property (UNDERVOLTAGE_RESET |=> q.st == S_LONG
    && q.flags[F_UV]) else $error("undervoltage not handled");
  a_monitor_reset : assert property (MONITOR_ENTRY_RESET && !long_src
    |=> RST_PIN_OE && q.st == S_DRIVE) else $error("monitor reset missing");
  a_stop_clear : assert property (q.st == S_RUN && STOP_OPCODE && !int_src && RST_PIN_IN
    |=> cif.value == '0) else $error("stop left counter");

  c_long_done : cover property (q.st == S_SYNC && q.long_seq ##1 q.st == S_RUN);
  c_stop_wake : cover property (q.st == S_RECOV ##1 q.st == S_RUN);
  c_pin_flag : cover property ($rose(q.flags[F_PIN]));
  c_wdog_fire : cover property (wdog_fire);
endmodule

/* File: verif/rcs_pin_partner.sv */
// Board side of the shared reset pin: pull-up and a peripheral that can pull it low.
`timescale 1ns/100ps
module rcs_pin_partner (
  // Device side of the open-drain pin.
  input  wire logic dev_out,
  input  wire logic dev_oe,
  // Request from a board peripheral to pull the pin low.
  input  wire logic board_pull,
  // Resolved pin level.
  output logic      pin
);
  // Either party may pull low; the pull-up wins once both let go.
  assign pin = ((dev_oe && !dev_out) || board_pull) ? 1'b0 : 1'b1;
endmodule

/* File: verif/test_rcs_sequencer.sv */
// Self-checking testbench of the reset and clock sequencer.
`timescale 1ns/100ps
module test_rcs_sequencer import rcs_pkg::*;;
  // Stimulus driven into the design.
  logic        clk, rstn, osc_t, pll_t, pwr, uv, mon_rst, ill_op, fetch, unmap;
  logic        stop_op, wait_r, wake, stop_en, short_stop_recovery_option, mon, brk, tv_rst, tv_irq;
  logic        cpu_wr, pull, reg_wr, reg_rd;
  logic [15:0] cpu_addr;
  logic [1:0]  reg_addr;
  logic [7:0]  reg_wdata;
  // Design outputs and the resolved pin.
  logic        bus_tick, cpu_en, per_en, pin_out, pin_oe, irl, wd_off, pin;
  logic [15:0] vec;
  logic [7:0]  rdata;
  // Counters of the run.
  int          miscompares = 0;
  int          n_tests = 0;
  int          cyc = 0;

  rcs_sequencer DUT (
    .REF_CLK(clk), .RESETN(rstn), .OSC_SELECT_CLOCK_TICK(osc_t),
    .PLL_DIV_CLOCK_TICK(pll_t), .BUS_TICK(bus_tick), .CPU_CLK_EN(cpu_en),
    .PERIPH_CLK_EN(per_en), .POWER_UP_PULSE(pwr), .UNDERVOLTAGE_RESET(uv),
    .MONITOR_ENTRY_RESET(mon_rst), .ILLEGAL_OPCODE(ill_op), .OPCODE_FETCH(fetch),
    .UNMAPPED_ADDR(unmap), .STOP_OPCODE(stop_op), .WAIT_REQ(wait_r), .WAKE_EVENT(wake),
    .STOP_ENABLE_OPTION(stop_en), .SHORT_STOP_RECOVERY_OPTION(short_stop_recovery_option),
    .MONITOR_MODE(mon), .BREAK_STATE(brk), .TEST_HIGH_VOLTAGE_RST(tv_rst),
    .TEST_HIGH_VOLTAGE_EXT_INTERRUPT_ONE_PIN(tv_irq), .CPU_WRITE(cpu_wr), .CPU_ADDR(cpu_addr),
    .RST_PIN_IN(pin), .RST_PIN_OUT(pin_out), .RST_PIN_OE(pin_oe),
    .INTERNAL_RESET_LINE(irl), .RESET_VECTOR(vec), .WATCHDOG_DISABLED(wd_off),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(rdata)
  );

  rcs_pin_partner board (.dev_out(pin_out), .dev_oe(pin_oe), .board_pull(pull), .pin(pin));

  // Free-running 20 MHz clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Cuts a hung run short; the checks need about 20000 cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      miscompares++;
      results();
    end
  end

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Compares one design value exactly.
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compares a cycle count against a small window.
  task automatic chkr(input string nm, input int lo, input int hi, input int g);
    n_tests++;
    if (g < lo || g > hi) begin
      miscompares++;
      $display("[ERR] %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask

  // Register port cycles: one strobe cycle, read data in the following cycle.
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Raises one request for a single cycle and returns just after it is taken.
  task automatic fire(input int k);
    @(posedge clk);
    case (k)
      0: ill_op <= 1'b1;
      1: begin fetch <= 1'b1; unmap <= 1'b1; end
      2: begin mon_rst <= 1'b1; mon <= 1'b1; end
      3: begin stop_op <= 1'b1; stop_en <= 1'b0; end
      4: unmap <= 1'b1;
      5: pwr <= 1'b1;
      6: uv <= 1'b1;
      7: wait_r <= 1'b1;
      8: wake <= 1'b1;
      default: stop_op <= 1'b1;
    endcase
    @(posedge clk);
    {ill_op, fetch, unmap, mon_rst, stop_op, pwr, uv, wait_r, wake} <= '0;
    stop_en <= 1'b1;
    #1;
  endtask

  // Waits, bounded, for the internal reset to release.
  task automatic wait_rel();
    int n;
    n = 0;
    while (irl !== 1'b0 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    // A release that never comes is a mismatch of its own.
    if (n >= 5000) begin
      miscompares++;
      $display("[ERR] reset release expected 0 seen %b", irl);
    end
  endtask

  // Measures how long the pin is driven and the internal reset held.
  task automatic seq(input string nm, input int e_oe, input int e_irl);
    int n_oe;
    int n_irl;
    n_oe = 0;
    n_irl = 0;
    while (irl === 1'b1 && n_irl < 5000) begin
      if (pin_oe === 1'b1) n_oe++;
      n_irl++;
      @(posedge clk);
      #1;
    end
    chkr({nm, " pin drive"}, e_oe, e_oe, n_oe);
    chkr({nm, " reset length"}, e_irl, e_irl, n_irl);
  endtask

  // Start-up after the reset input: clocks off, pin low, then power-up flags.
  task automatic t_startup();
    logic [7:0] d;
    #1;
    chk("startup pin", 16'h0, 16'(pin));
    chk("startup cpu clock", 16'h0, 16'(cpu_en));
    chk("startup periph clock", 16'h0, 16'(per_en));
    chk("startup pin level", 16'h0, 16'(pin_out));
    chk("user vector", VEC_USER, vec);
    wait_rel();
    chk("cpu released", 16'h1, 16'(cpu_en));
    rd(REG_CAUSE, d);
    chk("power flags", 16'(FLAGS_POR), 16'(d));
  endtask

  // Each short internal source but the watchdog: 32 cycles of pin drive, 67 of reset, its flag.
  task automatic t_internal();
    logic [7:0] d;
    int         fl [4] = '{F_BADOP, F_BADADR, F_MON, F_BADOP};
    for (int k = 0; k < 4; k++) begin
      fire(k);
      if (k == 2) chk("monitor vector", VEC_MON, vec);
      seq("internal", DRIVE_CYC, 67);
      @(posedge clk);
      mon <= 1'b0;
      rd(REG_CAUSE, d);
      chk("cause flag", 16'h1, 16'(d[fl[k]]));
    end
  endtask

  // A data access to an unmapped place leaves the device running.
  task automatic t_data();
    fire(4);
    repeat (3) @(posedge clk);
    #1;
    chk("data access reset", 16'h0, 16'(irl));
  endtask

  // Board pulls the pin low; the flag needs the minimum low time.
  task automatic t_pin(input int len, input logic e);
    logic [7:0] d;
    @(posedge clk);
    pull <= 1'b1;
    repeat (len) @(posedge clk);
    #1;
    if (len > 5) chk("pin halts", 16'h1, 16'(irl));
    @(posedge clk);
    pull <= 1'b0;
    wait_rel();
    rd(REG_CAUSE, d);
    chk("pin flag", 16'(e), 16'(d[F_PIN]));
  endtask

  // Wait mode stops the CPU clock only.
  task automatic t_wait();
    logic [7:0] d;
    fire(7);
    chk("wait cpu clock", 16'h0, 16'(cpu_en));
    chk("wait periph clock", 16'h1, 16'(per_en));
    rd(REG_STAT, d);
    chk("wait status", 16'h41, 16'(d));
    fire(8);
    chk("wait wake", 16'h1, 16'(cpu_en));
  endtask

  // Stop and wake: clocks stay off for the selected recovery delay.
  task automatic t_stop(input logic s, input int e);
    int n;
    @(posedge clk);
    short_stop_recovery_option <= s;
    fire(9);
    chk("stop periph clock", 16'h0, 16'(per_en));
    repeat (5) @(posedge clk);
    fire(8);
    n = 0;
    while (cpu_en !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    chkr("stop recovery", e, e + 2, n);
  endtask

  // Bus tick is the selected source divided by four; an unmapped read gives 0.
  task automatic t_bus(input logic sel, input int e);
    int         n;
    logic [7:0] d;
    wr(REG_CTRL, {7'h0, sel});
    n = 0;
    repeat (400) begin
      @(posedge clk);
      osc_t <= ~osc_t;
      pll_t <= 1'b1;
      #1;
      if (bus_tick === 1'b1) n++;
    end
    @(posedge clk);
    {osc_t, pll_t} <= 2'b00;
    chkr("bus ticks", e - 1, e + 1, n);
    rd(2'h3, d);
    chk("unmapped read", 16'h0, 16'(d));
  endtask

  // Watchdog disable by test voltage, then a service write.
  task automatic t_wdog();
    logic [4:0] tv [5] = '{5'h15, 5'h13, 5'h0d, 5'h0a, 5'h06};
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      {mon, brk, tv_rst, tv_irq} <= tv[i][4:1];
      #1;
      chk("watchdog off", 16'(tv[i][0]), 16'(wd_off));
    end
    @(posedge clk);
    {mon, brk, tv_rst, tv_irq, cpu_wr} <= 5'h01;
    cpu_addr <= SVC_ADDR;
    @(posedge clk);
    cpu_wr <= 1'b0;
  endtask

  // Power-up and undervoltage in mid-run: long hold and their flags.
  task automatic t_long(input int k, input int f);
    logic [7:0] d;
    fire(k);
    seq("long", LONG_CYC + DRIVE_CYC, 4163);
    rd(REG_CAUSE, d);
    chk("long flag", 16'h1, 16'(d[f]));
    if (k == 5) chk("power clears", 16'(FLAGS_POR), 16'(d));
  endtask

  // Main sequence.
  initial begin
    {osc_t, pll_t, pwr, uv, mon_rst, ill_op, fetch, unmap, stop_op} = '0;
    {wait_r, wake, mon, brk, tv_rst, tv_irq, cpu_wr, pull, reg_wr, reg_rd, rstn} = '0;
    {stop_en, short_stop_recovery_option} = 2'b11;
    cpu_addr = 16'h0000;
    reg_addr = 2'h0;
    reg_wdata = 8'h00;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_startup();
    t_pin(2, 1'b0);
    t_internal();
    t_data();
    t_pin(10, 1'b1);
    t_wait();
    t_stop(1'b1, SHORT_STOP_CYC);
    t_stop(1'b0, LONG_CYC);
    t_bus(1'b0, 50);
    t_bus(1'b1, 100);
    t_wdog();
    t_long(6, F_UV);
    t_long(5, F_POR);
    results();
  end
endmodule
